// [rtl/rscc_pkg.sv]
// Purpose: Shared constants and types for reset strap configuration capture
// Assumes: Straps are pin levels, asynchronous to core_clk_i
// Notes:   Reset values are the documented defaults
package rscc_pkg;

  // Boot select codes
  localparam logic [1:0] RSCC_BOOT_HOST   = 2'h0;
  localparam logic [1:0] RSCC_BOOT_ROM8   = 2'h1;
  localparam logic [1:0] RSCC_BOOT_ROM16  = 2'h2;
  localparam logic [1:0] RSCC_BOOT_ROM32  = 2'h3;

  // Debug mode codes
  localparam logic [1:0] RSCC_DBG_SCAN    = 2'h0;
  localparam logic [1:0] RSCC_DBG_RSVD    = 2'h1;
  localparam logic [1:0] RSCC_DBG_EMU     = 2'h3;

  // Values held before the first capture
  localparam logic       RSCC_RST_BYTE_ORDER = 1'h1;
  localparam logic       RSCC_RST_LANE_CORR  = 1'h1;
  localparam logic [1:0] RSCC_RST_BOOT       = 2'h1;
  localparam logic       RSCC_RST_CLK_SRC    = 1'h1;
  localparam logic [1:0] RSCC_RST_DEBUG      = 2'h3;

  // Strap positions on the host data pins
  localparam int unsigned RSCC_BYTE_ORDER_POS = 8;
  localparam int unsigned RSCC_LANE_CORR_POS  = 12;
  localparam int unsigned RSCC_BOOT_POS       = 3;

  // Synchroniser depth
  localparam int unsigned RSCC_SYNC_STAGES = 2;

  // Core clock multipliers
  localparam logic [2:0] RSCC_MULT_X1 = 3'h1;
  localparam logic [2:0] RSCC_MULT_X4 = 3'h4;

  // Boot space widths in bits
  localparam logic [5:0] RSCC_WIDTH_8  = 6'h08;
  localparam logic [5:0] RSCC_WIDTH_16 = 6'h10;
  localparam logic [5:0] RSCC_WIDTH_32 = 6'h20;

  typedef struct packed {
    logic       byte_order_strap;
    logic       lane_correction_strap;
    logic [1:0] boot_select_strap;
    logic       clock_source_strap;
    logic [1:0] debug_mode_pins;
  } rscc_straps_t;

  localparam rscc_straps_t RSCC_RST_STRAPS = '{RSCC_RST_BYTE_ORDER, RSCC_RST_LANE_CORR, RSCC_RST_BOOT,
                                               RSCC_RST_CLK_SRC, RSCC_RST_DEBUG};

  localparam int unsigned RSCC_STRAP_W = 7;

  typedef enum logic [1:0] {
    RSCC_LANE_LOW,
    RSCC_LANE_HIGH
  } rscc_lane_t;

endpackage

// [rtl/rscc_sync.sv]
// Purpose: Two-flop synchroniser for a strap bus
// Assumes: Input is asynchronous to core_clk_i
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
module rscc_sync
  import rscc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  input  wire logic [W-1:0] reset_val_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stage;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stage;

  always_comb begin
    next_meta  = async_i;
    next_stage = meta;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta  <= '0;
      stage <= '0;
    end else begin
      meta  <= next_meta;
      stage <= next_stage;
    end
  end

  // Reset value unused here: stage is gated by the caller
  assign sync_o = stage;

endmodule

// [rtl/rscc_top.sv]
// Purpose: Capture configuration straps in the first edges after reset release, hold them after
// Assumes: rstn_i is the device reset; straps held steady throughout reset
// Notes:   Decoded settings come from flops and stay frozen until next reset
`timescale 1ns/10ps
module rscc_top
  import rscc_pkg::*;
#(
  parameter bit PROG_CLOCK = 1'b0
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [15:0]  host_port_data_pins_i,
  input  wire logic         clock_source_strap_i,
  input  wire logic [1:0]   debug_mode_pins_i,
  output logic              cfg_valid_o,
  output rscc_straps_t      straps_o,
  output logic              little_endian_o,
  output logic              narrow_lane_steering_o,
  output rscc_lane_t        narrow_lane_o,
  output logic              boot_from_host_o,
  output logic [5:0]        boot_space_select_o,
  output logic [2:0]        core_clk_mult_o,
  output logic              clock_strap_reserved_o,
  output logic              boundary_scan_o,
  output logic              emulation_o,
  output logic              debug_reserved_o,
  output logic              functional_en_o
);

  rscc_straps_t    raw;
  rscc_straps_t    synced;
  rscc_straps_t    held;
  rscc_straps_t    next_held;
  logic            captured;

  // Capture sequence: two edges fill the synchroniser, the third latches
  typedef enum logic [1:0] {
    RSCC_CAP_FILL_A,
    RSCC_CAP_FILL_B,
    RSCC_CAP_LATCH,
    RSCC_CAP_HELD
  } rscc_cap_state_t;

  rscc_cap_state_t state;
  rscc_cap_state_t next_state;

  // Byte order, lane and boot straps taken from host data pins; other bits ignored
  always_comb begin
    raw.byte_order_strap      = host_port_data_pins_i[RSCC_BYTE_ORDER_POS];
    raw.lane_correction_strap = host_port_data_pins_i[RSCC_LANE_CORR_POS];
    raw.boot_select_strap     = host_port_data_pins_i[RSCC_BOOT_POS +: 2];
    raw.clock_source_strap    = clock_source_strap_i;
    raw.debug_mode_pins       = debug_mode_pins_i;
  end

  rscc_sync #(
    .W (RSCC_STRAP_W)
  ) u_sync (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .async_i     (raw),
    .reset_val_i (raw),
    .sync_o      (synced)
  );

  // Pin activity after the latch state is ignored until the next reset
  always_comb begin
    next_state = state;
    next_held  = held;
    case (state)
      RSCC_CAP_FILL_A: begin
        next_state = RSCC_CAP_FILL_B;
      end
      RSCC_CAP_FILL_B: begin
        next_state = RSCC_CAP_LATCH;
      end
      RSCC_CAP_LATCH: begin
        next_held  = synced;
        next_state = RSCC_CAP_HELD;
      end
      RSCC_CAP_HELD: begin
        next_state = RSCC_CAP_HELD;
      end
      default: begin
        next_state = RSCC_CAP_FILL_A;
      end
    endcase
  end

  assign captured = (state == RSCC_CAP_HELD);

  // Held straps keep their defaults until the latch state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= RSCC_CAP_FILL_A;
      held  <= RSCC_RST_STRAPS;
    end else begin
      state <= next_state;
      held  <= next_held;
    end
  end

  function automatic logic [5:0] boot_width(input logic [1:0] code);
    case (code)
      RSCC_BOOT_ROM8:  boot_width = RSCC_WIDTH_8;
      RSCC_BOOT_ROM16: boot_width = RSCC_WIDTH_16;
      RSCC_BOOT_ROM32: boot_width = RSCC_WIDTH_32;
      default:         boot_width = RSCC_WIDTH_32;
    endcase
  endfunction

  // Decoded outputs, registered from the held straps
  logic         next_valid;
  logic         next_le;
  logic         next_steer;
  rscc_lane_t   next_lane;
  logic         next_boot_host;
  logic [5:0]   next_space;
  logic [2:0]   next_mult;
  logic         next_clk_rsvd;
  logic         next_scan;
  logic         next_emu;
  logic         next_dbg_rsvd;
  logic         next_func;

  always_comb begin
    next_le    = held.byte_order_strap;
    next_steer = held.lane_correction_strap;
    next_lane  = RSCC_LANE_LOW;
    if (held.lane_correction_strap && !held.byte_order_strap) begin
      next_lane = RSCC_LANE_HIGH;
    end
    next_boot_host = 1'b0;
    case (held.boot_select_strap)
      RSCC_BOOT_HOST: begin
        next_boot_host = 1'b1;
      end
      default: begin
        next_boot_host = 1'b0;
      end
    endcase
    next_space = boot_width(held.boot_select_strap);
    // Programmable-clock builds never multiply; strap 0 is only flagged
    if (PROG_CLOCK) begin
      next_mult     = RSCC_MULT_X1;
      next_clk_rsvd = !held.clock_source_strap;
    end else begin
      next_mult     = held.clock_source_strap ? RSCC_MULT_X4 : RSCC_MULT_X1;
      next_clk_rsvd = 1'b0;
    end
    next_scan     = 1'b0;
    next_emu      = 1'b0;
    next_dbg_rsvd = 1'b0;
    // Code 10 is undocumented and raises no flag
    case (held.debug_mode_pins)
      RSCC_DBG_SCAN: begin
        next_scan = 1'b1;
      end
      RSCC_DBG_EMU: begin
        next_emu = 1'b1;
      end
      RSCC_DBG_RSVD: begin
        next_dbg_rsvd = 1'b1;
      end
      default: begin
        next_scan = 1'b0;
      end
    endcase
    // Functional operation in scan and emulation alike
    next_func  = captured;
    next_valid = captured;
  end

  // Outputs trail the held straps by one edge

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_valid_o            <= 1'b0;
      straps_o               <= RSCC_RST_STRAPS;
      little_endian_o        <= RSCC_RST_BYTE_ORDER;
      narrow_lane_steering_o <= RSCC_RST_LANE_CORR;
      narrow_lane_o          <= RSCC_LANE_LOW;
      boot_from_host_o       <= 1'b0;
      boot_space_select_o    <= RSCC_WIDTH_8;
      core_clk_mult_o        <= PROG_CLOCK ? RSCC_MULT_X1 : RSCC_MULT_X4;
      clock_strap_reserved_o <= 1'b0;
      boundary_scan_o        <= 1'b0;
      emulation_o            <= 1'b1;
      debug_reserved_o       <= 1'b0;
      functional_en_o        <= 1'b0;
    end else begin
      cfg_valid_o            <= next_valid;
      straps_o               <= held;
      little_endian_o        <= next_le;
      narrow_lane_steering_o <= next_steer;
      narrow_lane_o          <= next_lane;
      boot_from_host_o       <= next_boot_host;
      boot_space_select_o    <= next_space;
      core_clk_mult_o        <= next_mult;
      clock_strap_reserved_o <= next_clk_rsvd;
      boundary_scan_o        <= next_scan;
      emulation_o            <= next_emu;
      debug_reserved_o       <= next_dbg_rsvd;
      functional_en_o        <= next_func;
    end
  end

endmodule

// [dv/rscc_checker.sv]
// Purpose: Assertions on the strap capture outputs
// Assumes: Bound to rscc_top
// Notes:   Decode checks hold while cfg_valid_o is high
`timescale 1ns/10ps
module rscc_checker
  import rscc_pkg::*;
#(
  parameter bit PROG_CLOCK = 1'b0
) (
  input wire logic         core_clk_i,
  input wire logic         rstn_i,
  input wire logic [15:0]  host_port_data_pins_i,
  input wire logic         clock_source_strap_i,
  input wire logic [1:0]   debug_mode_pins_i,
  input wire logic         cfg_valid_o,
  input wire rscc_straps_t straps_o,
  input wire logic         little_endian_o,
  input wire logic         narrow_lane_steering_o,
  input wire rscc_lane_t   narrow_lane_o,
  input wire logic         boot_from_host_o,
  input wire logic [5:0]   boot_space_select_o,
  input wire logic [2:0]   core_clk_mult_o,
  input wire logic         clock_strap_reserved_o,
  input wire logic         boundary_scan_o,
  input wire logic         emulation_o,
  input wire logic         debug_reserved_o,
  input wire logic         functional_en_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  rscc_straps_t s;
  logic         v;
  assign s = straps_o;
  assign v = cfg_valid_o;
  capture_a: assert property ($rose(rstn_i) |-> !v [*2] ##[1:3] v) else $error("capture late");
  hold_a: assert property (v && $past(v) |-> $stable(s) && $stable(functional_en_o)) else $error("held moved");
  endian_a: assert property (v |-> little_endian_o == s.byte_order_strap) else $error("byte order");
  steer_a: assert property (v |-> narrow_lane_steering_o == s.lane_correction_strap) else $error("steer");
  lane_a: assert property (v |-> (narrow_lane_o == RSCC_LANE_HIGH) ==
    (s.lane_correction_strap && !s.byte_order_strap)) else $error("narrow lane");
  boot_a: assert property (v |-> boot_from_host_o == (s.boot_select_strap == RSCC_BOOT_HOST)) else $error("boot");
  space_a: assert property (v |-> boot_space_select_o ==
    ((s.boot_select_strap == RSCC_BOOT_ROM8) ? RSCC_WIDTH_8 :
     (s.boot_select_strap == RSCC_BOOT_ROM16) ? RSCC_WIDTH_16 : RSCC_WIDTH_32)) else $error("boot width");
  mult_a: assert property (v |-> core_clk_mult_o ==
    ((s.clock_source_strap && !PROG_CLOCK) ? RSCC_MULT_X4 : RSCC_MULT_X1)) else $error("mult");
  clk_rsvd_a: assert property (v |-> clock_strap_reserved_o ==
    (PROG_CLOCK && !s.clock_source_strap)) else $error("clock reserved");
  dbg_mode_a: assert property (v |-> {boundary_scan_o, emulation_o, debug_reserved_o} ==
    {s.debug_mode_pins == RSCC_DBG_SCAN, s.debug_mode_pins == RSCC_DBG_EMU,
     s.debug_mode_pins == RSCC_DBG_RSVD}) else $error("debug mode");
  func_en_a: assert property (v |-> functional_en_o) else $error("functional off");
  cover property (v && boundary_scan_o);
  cover property (v && narrow_lane_o == RSCC_LANE_HIGH);
  cover property ($rose(v));
endmodule
bind rscc_top rscc_checker #(
  .PROG_CLOCK (PROG_CLOCK)
) u_chk (
  .core_clk_i             (core_clk_i),
  .rstn_i                 (rstn_i),
  .host_port_data_pins_i  (host_port_data_pins_i),
  .clock_source_strap_i   (clock_source_strap_i),
  .debug_mode_pins_i      (debug_mode_pins_i),
  .cfg_valid_o            (cfg_valid_o),
  .straps_o               (straps_o),
  .little_endian_o        (little_endian_o),
  .narrow_lane_steering_o (narrow_lane_steering_o),
  .narrow_lane_o          (narrow_lane_o),
  .boot_from_host_o       (boot_from_host_o),
  .boot_space_select_o    (boot_space_select_o),
  .core_clk_mult_o        (core_clk_mult_o),
  .clock_strap_reserved_o (clock_strap_reserved_o),
  .boundary_scan_o        (boundary_scan_o),
  .emulation_o            (emulation_o),
  .debug_reserved_o       (debug_reserved_o),
  .functional_en_o        (functional_en_o)
);

// [dv/rscc_board.sv]
// Purpose: Board pulls and strap drivers for the strap pins; reset is an input
// Assumes: Straps held until capture is done
// Notes:   After capture the pins carry toggling traffic
`timescale 1ns/10ps
module rscc_board
  import rscc_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire rscc_straps_t cfg_i,
  output logic [15:0]       host_o,
  output logic              clk_src_o,
  output logic [1:0]        dbg_o
);
  logic [3:0]  n;
  logic [15:0] pat = 16'hA5C3;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      n <= 4'h0;
    else if (n != 4'hF)
      n <= n + 4'h1;
  end
  always @(posedge core_clk_i) pat <= ~pat + 16'h1357;
  // Strap drive: pins follow cfg_i while reset is low and for four edges after release
  always_comb begin
    if (!rstn_i || n < 4'h4) begin
      host_o = 16'hFFEF;
      host_o[8] = cfg_i.byte_order_strap;
      host_o[12] = cfg_i.lane_correction_strap;
      host_o[4:3] = cfg_i.boot_select_strap;
      clk_src_o = cfg_i.clock_source_strap;
      dbg_o = cfg_i.debug_mode_pins;
    end else begin
      host_o = pat;
      clk_src_o = pat[0];
      dbg_o = pat[2:1];
    end
  end
endmodule

// [dv/rscc_top_test.sv]
// Purpose: Self-checking bench for strap capture
// Assumes: A fixed-PLL and a programmable-clock build share the pins
// Notes:   Each boot resets the block with new straps
`timescale 1ns/10ps
module rscc_top_test;
  import rscc_pkg::*;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  rscc_straps_t cfg = 7'h00;
  rscc_straps_t st;
  rscc_lane_t   lane;
  logic [15:0]  hp;
  logic [1:0]   dbg;
  logic [5:0]   width;
  logic [2:0]   mult;
  logic [2:0]   mult_p;
  logic         cres_p;
  logic         cs, valid, le, steer, host, cres, scan, emu, drsv, fen;
  int           n_fail = 0;
  int           num_checks = 0;
  always #2 clk = ~clk;
  rscc_board board (.core_clk_i(clk), .rstn_i(rstn), .cfg_i(cfg), .host_o(hp), .clk_src_o(cs), .dbg_o(dbg));
  rscc_top dut (.core_clk_i(clk), .rstn_i(rstn), .host_port_data_pins_i(hp), .clock_source_strap_i(cs),
    .debug_mode_pins_i(dbg), .cfg_valid_o(valid), .straps_o(st), .little_endian_o(le),
    .narrow_lane_steering_o(steer), .narrow_lane_o(lane), .boot_from_host_o(host),
    .boot_space_select_o(width), .core_clk_mult_o(mult), .clock_strap_reserved_o(cres),
    .boundary_scan_o(scan), .emulation_o(emu), .debug_reserved_o(drsv), .functional_en_o(fen));
  rscc_top #(.PROG_CLOCK(1'b1)) dut_prog (.core_clk_i(clk), .rstn_i(rstn), .host_port_data_pins_i(hp),
    .clock_source_strap_i(cs), .debug_mode_pins_i(dbg), .cfg_valid_o(), .straps_o(), .little_endian_o(),
    .narrow_lane_steering_o(), .narrow_lane_o(), .boot_from_host_o(), .boot_space_select_o(),
    .core_clk_mult_o(mult_p), .clock_strap_reserved_o(cres_p), .boundary_scan_o(), .emulation_o(),
    .debug_reserved_o(), .functional_en_o());
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task boot(input rscc_straps_t s);
    int i;
    @(posedge clk);
    cfg <= s;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 10 && valid !== 1'b1; i++) @(posedge clk);
    #1;
    if (valid !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  task expect_cfg(input rscc_straps_t s);
    chk(st, s);
    chk(le, s.byte_order_strap);
    chk(steer, s.lane_correction_strap);
    chk(lane, (s.lane_correction_strap && !s.byte_order_strap) ? RSCC_LANE_HIGH : RSCC_LANE_LOW);
    chk(host, s.boot_select_strap == 2'h0);
    chk(width, s.boot_select_strap == 2'h1 ? 6'h08 : s.boot_select_strap == 2'h2 ? 6'h10 : 6'h20);
    chk(mult, s.clock_source_strap ? 3'h4 : 3'h1);
    chk(cres, 1'h0);
    chk({scan, emu, drsv}, {s.debug_mode_pins == 2'h0, s.debug_mode_pins == 2'h3, s.debug_mode_pins == 2'h1});
    chk(fen, 1'h1);
    chk(mult_p, 3'h1);
    chk(cres_p, !s.clock_source_strap);
  endtask
  task t_defaults;
    int i;
    repeat (2) @(posedge clk);
    #1;
    chk({valid, st, le, lane, mult, emu, scan}, {1'h0, 7'h6F, 1'h1, 2'h0, 3'h4, 1'h1, 1'h0});
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      #1;
      chk({valid, st, fen, mult_p}, {1'h0, 7'h6F, 1'h0, 3'h1});
    end
  endtask
  task t_codes;
    logic [1:0]   i;
    rscc_straps_t s;
    for (int k = 0; k < 4; k++) begin
      i = k[1:0];
      s = {i[0], i[1], i, i[0], ~i};
      boot(s);
      expect_cfg(s);
    end
  endtask
  task t_hold;
    boot(7'h4A);
    repeat (20) @(posedge clk);
    #1;
    expect_cfg(7'h4A);
  endtask
  initial begin
    t_defaults();
    t_codes();
    t_hold();
    end_sim();
  end
endmodule
